// File: rtl/tv_ctrl_pkg.sv
package tv_ctrl_pkg;

  // Operating states
  typedef enum logic [2:0] {
    PWR_NORMAL        = 3'h0,
    PWR_DOWN          = 3'h1,
    PWR_FULL_DOWN     = 3'h2,
    PWR_SVIDEO_OFF    = 3'h3,
    PWR_COMPOSITE_OFF = 3'h4
  } power_state_t;

  // Flicker content levels; code 3 is illegal
  typedef enum logic [1:0] {
    FLICKER_LOW    = 2'h0,
    FLICKER_MEDIUM = 2'h1,
    FLICKER_HIGH   = 2'h2
  } flicker_level_t;

  // Filter and bandwidth settings
  typedef struct packed {
    flicker_level_t luma_flicker;
    flicker_level_t chroma_flicker;
    logic           text_enhance;
    logic [1:0]     chroma_bw_select;
    logic           composite_luma_bw;
    logic [1:0]     svideo_luma_bw;
    logic           luma_peaking_enable;
    logic           vbi_pass_enable;
  } filter_cfg_t;

  // Power domain enables
  typedef struct packed {
    logic core_enable;
    logic svideo_dac_on;
    logic composite_dac_on;
    logic bus_clock_out_enable;
    logic pixel_clock_out_enable;
    logic serial_port_enable;
  } power_ctl_t;

  localparam filter_cfg_t  FILTER_CFG_RESET  = 12'h000;
  localparam power_ctl_t   POWER_CTL_RESET   = 6'h39;
  localparam power_state_t POWER_STATE_RESET = PWR_NORMAL;
  localparam int           DAC_GAIN_BIT      = 6;
  localparam logic [9:0]   VBI_FIRST_LINE    = 10'h00A;
  localparam logic [9:0]   VBI_LAST_LINE     = 10'h015;
  localparam logic [4:0]   MODE_LAST         = 5'h1C;
  localparam logic [4:0]   MODE_RESET        = 5'h00;
  localparam logic [2:0]   DEFLICKER_MIN     = 3'h2;
  localparam logic [2:0]   DEFLICKER_MAX     = 3'h5;
  localparam logic [2:0]   DEFLICKER_RESET   = 3'h2;
  localparam int           MODE_COUNT        = 29;
  localparam logic [57:0]  DEFLICKER_TABLE   = 58'h2AAAAAAAAAAAAAA;
  localparam logic [1:0]   SV_BAND_WIDEST    = 2'h2;
  localparam logic [1:0]   CONN_RESET        = 2'h0;

endpackage

// File: rtl/tv_encoder_power_filter_ctrl.sv
`timescale 1ns/1ps
module tv_encoder_power_filter_ctrl
  import tv_ctrl_pkg::*;
#(
  parameter logic [2*MODE_COUNT-1:0] DEFLICKER_LINES = DEFLICKER_TABLE
) (
  input  wire logic         clock_in,                  // 50 MHz clock
  input  wire logic         rst_n_in,                  // Async reset, active low
  input  wire logic [7:0]   input_data_format_in,      // Input format register value
  input  wire power_state_t power_state_in,            // Requested operating state
  input  wire filter_cfg_t  filter_cfg_in,             // Requested filter settings
  input  wire logic [4:0]   display_mode_in,           // Display mode number
  input  wire logic         bus_clock_is_output_in,    // Bus clock pin set as output
  input  wire logic         master_clock_mode_in,      // Master clock mode active
  input  wire logic         field_start_in,            // Pulse at each field start
  input  wire logic [9:0]   line_number_in,            // Current video line
  input  wire logic         svideo_sense_in,           // TV sensed on S-Video pin
  input  wire logic         composite_sense_in,        // TV sensed on composite pin
  output filter_cfg_t       filter_cfg_out,            // Applied filter settings
  output logic [2:0]        deflicker_lines_out,       // Deflicker span in lines
  output logic              dac_gain_select_out,       // 1: higher reference level
  output power_ctl_t        power_ctl_out,             // Power domain enables
  output power_state_t      active_state_out,          // Applied operating state
  output logic [1:0]        connection_status_out,     // {svideo, composite} sensed
  output logic              vbi_pass_active_out,       // VBI pass-through this line
  output logic [1:0]        svideo_luma_band_out,      // S-Video luma band 0..2
  output logic              svideo_peaking_active_out  // Peaking applied
);

  // Apply changes at field start, or at once when no fields run
  logic video_running;
  logic apply_now;
  assign video_running = (active_state_out == PWR_NORMAL) ||
                         (active_state_out == PWR_SVIDEO_OFF) ||
                         (active_state_out == PWR_COMPOSITE_OFF);
  assign apply_now     = field_start_in || !video_running;

  // Illegal flicker codes clamp to the high setting
  filter_cfg_t next_filter_cfg;
  always_comb begin
    next_filter_cfg = filter_cfg_in;
    if (filter_cfg_in.luma_flicker == 2'h3) begin
      next_filter_cfg.luma_flicker = FLICKER_HIGH;
    end
    if (filter_cfg_in.chroma_flicker == 2'h3) begin
      next_filter_cfg.chroma_flicker = FLICKER_HIGH;
    end
  end

  // Unknown state codes fall back to normal
  power_state_t next_state;
  assign next_state = (power_state_in > PWR_COMPOSITE_OFF) ? PWR_NORMAL
                                                            : power_state_in;

  // Modes past the last one clamp to it
  logic [4:0] next_mode;
  assign next_mode = (display_mode_in > MODE_LAST) ? MODE_LAST : display_mode_in;

  // Applied settings, taken only at a safe point
  logic [4:0] active_mode;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_state_out    <= POWER_STATE_RESET;
      filter_cfg_out      <= FILTER_CFG_RESET;
      dac_gain_select_out <= 1'b0;
      active_mode         <= MODE_RESET;
    end else if (apply_now) begin
      active_state_out    <= next_state;
      filter_cfg_out      <= next_filter_cfg;
      dac_gain_select_out <= input_data_format_in[DAC_GAIN_BIT];
      active_mode         <= next_mode;
    end
  end

  // Power enables per operating state
  power_ctl_t next_power_ctl;
  always_comb begin
    next_power_ctl                        = POWER_CTL_RESET;
    next_power_ctl.serial_port_enable     = 1'b1;
    next_power_ctl.bus_clock_out_enable   = bus_clock_is_output_in;
    next_power_ctl.pixel_clock_out_enable = 1'b1;
    unique case (active_state_out)
      PWR_NORMAL: begin
        next_power_ctl.core_enable      = 1'b1;
        next_power_ctl.svideo_dac_on    = 1'b1;
        next_power_ctl.composite_dac_on = 1'b1;
      end
      PWR_DOWN: begin
        next_power_ctl.core_enable            = 1'b0;
        next_power_ctl.svideo_dac_on          = 1'b0;
        next_power_ctl.composite_dac_on       = 1'b0;
        next_power_ctl.bus_clock_out_enable   = bus_clock_is_output_in;
        next_power_ctl.pixel_clock_out_enable = master_clock_mode_in;
      end
      PWR_FULL_DOWN: begin
        next_power_ctl.core_enable            = 1'b0;
        next_power_ctl.svideo_dac_on          = 1'b0;
        next_power_ctl.composite_dac_on       = 1'b0;
        next_power_ctl.bus_clock_out_enable   = 1'b0;
        next_power_ctl.pixel_clock_out_enable = 1'b0;
      end
      PWR_SVIDEO_OFF: begin
        next_power_ctl.core_enable      = 1'b1;
        next_power_ctl.svideo_dac_on    = 1'b0;
        next_power_ctl.composite_dac_on = 1'b1;
      end
      PWR_COMPOSITE_OFF: begin
        next_power_ctl.core_enable      = 1'b1;
        next_power_ctl.svideo_dac_on    = 1'b1;
        next_power_ctl.composite_dac_on = 1'b0;
      end
      default: begin
        next_power_ctl = POWER_CTL_RESET;
      end
    endcase
  end

  // Deflicker span looked up from the mode
  logic [1:0] deflicker_code;
  logic [2:0] next_deflicker;
  assign deflicker_code = DEFLICKER_LINES[{active_mode, 1'b0} +: 2];
  assign next_deflicker = DEFLICKER_MIN + {1'b0, deflicker_code};

  // VBI window and S-Video band decode
  logic       in_vbi_window;
  logic       next_vbi_active;
  logic [1:0] next_sv_band;
  logic       next_peaking;
  assign in_vbi_window   = (line_number_in >= VBI_FIRST_LINE) &&
                           (line_number_in <= VBI_LAST_LINE);
  assign next_vbi_active = filter_cfg_out.vbi_pass_enable && in_vbi_window &&
                           video_running;
  assign next_sv_band    = filter_cfg_out.svideo_luma_bw[1] ? SV_BAND_WIDEST
                         : filter_cfg_out.svideo_luma_bw;
  assign next_peaking    = filter_cfg_out.luma_peaking_enable &&
                           (next_sv_band != SV_BAND_WIDEST);

  // Registered outputs
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_ctl_out             <= POWER_CTL_RESET;
      deflicker_lines_out       <= DEFLICKER_RESET;
      vbi_pass_active_out       <= 1'b0;
      svideo_luma_band_out      <= 2'h0;
      svideo_peaking_active_out <= 1'b0;
    end else begin
      power_ctl_out             <= next_power_ctl;
      deflicker_lines_out       <= next_deflicker;
      vbi_pass_active_out       <= next_vbi_active;
      svideo_luma_band_out      <= next_sv_band;
      svideo_peaking_active_out <= next_peaking;
    end
  end

  // Sense pins pass three flip-flops
  logic [1:0] sense_s1;
  logic [1:0] sense_s2;
  logic [1:0] sense_s3;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sense_s1 <= CONN_RESET;
      sense_s2 <= CONN_RESET;
      sense_s3 <= CONN_RESET;
    end else begin
      sense_s1 <= {svideo_sense_in, composite_sense_in};
      sense_s2 <= sense_s1;
      sense_s3 <= sense_s2;
    end
  end

  // Status bit follows once the late stages agree
  logic [1:0] sense_agree;
  assign sense_agree = ~(sense_s2 ^ sense_s3);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      connection_status_out <= CONN_RESET;
    end else begin
      connection_status_out <= (sense_s2 & sense_agree) |
                               (connection_status_out & ~sense_agree);
    end
  end

  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  property p_normal_all_on;
    active_state_out == PWR_NORMAL |=> power_ctl_out.core_enable &&
      power_ctl_out.svideo_dac_on && power_ctl_out.composite_dac_on &&
      power_ctl_out.pixel_clock_out_enable;
  endproperty
  a_normal_all_on: assert property (p_normal_all_on)
    else $error("normal state lost a function");

  property p_pd_bus_clock;
    (active_state_out == PWR_DOWN) && bus_clock_is_output_in
      |=> power_ctl_out.bus_clock_out_enable && !power_ctl_out.core_enable;
  endproperty
  a_pd_bus_clock: assert property (p_pd_bus_clock)
    else $error("bus clock stopped in power down");

  property p_pd_pixel_clock;
    (active_state_out == PWR_DOWN) && master_clock_mode_in
      |=> power_ctl_out.pixel_clock_out_enable;
  endproperty
  a_pd_pixel_clock: assert property (p_pd_pixel_clock)
    else $error("pixel clock stopped in master mode");

  property p_svideo_off;
    active_state_out == PWR_SVIDEO_OFF
      |=> !power_ctl_out.svideo_dac_on && power_ctl_out.composite_dac_on;
  endproperty
  a_svideo_off: assert property (p_svideo_off)
    else $error("S-Video off DAC enables wrong");

  property p_composite_off;
    active_state_out == PWR_COMPOSITE_OFF
      |=> power_ctl_out.svideo_dac_on && !power_ctl_out.composite_dac_on;
  endproperty
  a_composite_off: assert property (p_composite_off)
    else $error("composite off DAC enables wrong");

  property p_full_down;
    active_state_out == PWR_FULL_DOWN |=> power_ctl_out.serial_port_enable &&
      !power_ctl_out.core_enable && !power_ctl_out.bus_clock_out_enable &&
      !power_ctl_out.pixel_clock_out_enable;
  endproperty
  a_full_down: assert property (p_full_down)
    else $error("full power down enables wrong");

  property p_dac_gain;
    field_start_in |=> dac_gain_select_out == $past(input_data_format_in[DAC_GAIN_BIT]);
  endproperty
  a_dac_gain: assert property (p_dac_gain)
    else $error("DAC gain select not taken from bit 6");

  property p_field_apply;
    field_start_in |=> filter_cfg_out.chroma_bw_select == $past(filter_cfg_in.chroma_bw_select)
      && active_state_out == $past(next_state);
  endproperty
  a_field_apply: assert property (p_field_apply)
    else $error("settings not applied at field start");

  property p_deflicker_range;
    deflicker_lines_out >= DEFLICKER_MIN && deflicker_lines_out <= DEFLICKER_MAX;
  endproperty
  a_deflicker_range: assert property (p_deflicker_range)
    else $error("deflicker span out of range");

  sequence s_vbi_line;
    filter_cfg_out.vbi_pass_enable && video_running &&
      line_number_in >= VBI_FIRST_LINE && line_number_in <= VBI_LAST_LINE;
  endsequence
  property p_vbi_pass;
    s_vbi_line |=> vbi_pass_active_out;
  endproperty
  a_vbi_pass: assert property (p_vbi_pass)
    else $error("VBI line not passed through");

  property p_vbi_outside;
    line_number_in == VBI_LAST_LINE + 10'h001 |=> !vbi_pass_active_out;
  endproperty
  a_vbi_outside: assert property (p_vbi_outside)
    else $error("VBI pass-through past last line");

  sequence s_sv_sensed;
    svideo_sense_in [*4];
  endsequence
  sequence s_sv_absent;
    !svideo_sense_in [*4];
  endsequence
  property p_sense_on;
    s_sv_sensed |=> connection_status_out[1];
  endproperty
  a_sense_on: assert property (p_sense_on)
    else $error("S-Video TV not reported");
  property p_sense_off;
    s_sv_absent |=> !connection_status_out[1];
  endproperty
  a_sense_off: assert property (p_sense_off)
    else $error("S-Video TV reported while absent");

  property p_widest_band;
    filter_cfg_out.svideo_luma_bw[1] |=> svideo_luma_band_out == SV_BAND_WIDEST &&
      !svideo_peaking_active_out;
  endproperty
  a_widest_band: assert property (p_widest_band)
    else $error("widest S-Video band decoded wrong");

  property p_peaking;
    !filter_cfg_out.svideo_luma_bw[1] && filter_cfg_out.luma_peaking_enable
      |=> svideo_peaking_active_out;
  endproperty
  a_peaking: assert property (p_peaking)
    else $error("peaking not applied to narrow band");

  property p_flicker_clamp;
    field_start_in && filter_cfg_in.luma_flicker == 2'h3
      |=> filter_cfg_out.luma_flicker == FLICKER_HIGH;
  endproperty
  a_flicker_clamp: assert property (p_flicker_clamp)
    else $error("illegal flicker code not clamped to high");

endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import tv_ctrl_pkg::*;

  logic         clock_in;
  logic         rst_n_in;
  logic [7:0]   input_data_format_in;
  power_state_t power_state_in;
  filter_cfg_t  filter_cfg_in;
  logic [4:0]   display_mode_in;
  logic         bus_clock_is_output_in;
  logic         master_clock_mode_in;
  logic         field_start_in;
  logic [9:0]   line_number_in;
  logic         svideo_sense_in;
  logic         composite_sense_in;
  filter_cfg_t  filter_cfg_out;
  logic [2:0]   deflicker_lines_out;
  logic         dac_gain_select_out;
  power_ctl_t   power_ctl_out;
  power_state_t active_state_out;
  logic [1:0]   connection_status_out;
  logic         vbi_pass_active_out;
  logic [1:0]   svideo_luma_band_out;
  logic         svideo_peaking_active_out;
  int           err_total;
  int           n_tests;
  int           cycles;
  filter_cfg_t  cfg_a;
  filter_cfg_t  cfg_b;
  power_state_t seq [6];

  tv_encoder_power_filter_ctrl dut (
    .clock_in                  (clock_in),
    .rst_n_in                  (rst_n_in),
    .input_data_format_in      (input_data_format_in),
    .power_state_in            (power_state_in),
    .filter_cfg_in             (filter_cfg_in),
    .display_mode_in           (display_mode_in),
    .bus_clock_is_output_in    (bus_clock_is_output_in),
    .master_clock_mode_in      (master_clock_mode_in),
    .field_start_in            (field_start_in),
    .line_number_in            (line_number_in),
    .svideo_sense_in           (svideo_sense_in),
    .composite_sense_in        (composite_sense_in),
    .filter_cfg_out            (filter_cfg_out),
    .deflicker_lines_out       (deflicker_lines_out),
    .dac_gain_select_out       (dac_gain_select_out),
    .power_ctl_out             (power_ctl_out),
    .active_state_out          (active_state_out),
    .connection_status_out     (connection_status_out),
    .vbi_pass_active_out       (vbi_pass_active_out),
    .svideo_luma_band_out      (svideo_luma_band_out),
    .svideo_peaking_active_out (svideo_peaking_active_out)
  );

  // Free running 50 MHz clock
  always #10 clock_in = ~clock_in;

  // Hang guard
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%0h expected=%0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // Settings taken at a field start pulse, then let outputs settle
  task automatic field(input power_state_t s, input filter_cfg_t c, input logic [7:0] fmt);
    @(posedge clock_in);
    power_state_in       <= s;
    filter_cfg_in        <= c;
    input_data_format_in <= fmt;
    field_start_in       <= 1'b1;
    @(posedge clock_in);
    field_start_in       <= 1'b0;
    tick(2);
  endtask

  task automatic line_chk(input logic [9:0] l, input logic e);
    @(posedge clock_in);
    line_number_in <= l;
    tick(2);
    check(vbi_pass_active_out, e);
  endtask

  // Expected power enables {core, sv, cv, bco, pix, serial}
  function automatic power_ctl_t pexp(power_state_t s, logic b, logic m);
    case (s)
      PWR_DOWN:          return {3'h0, b, m, 1'b1};
      PWR_FULL_DOWN:     return 6'h01;
      PWR_SVIDEO_OFF:    return {3'h5, b, 2'h3};
      PWR_COMPOSITE_OFF: return {3'h6, b, 2'h3};
      default:           return {3'h7, b, 2'h3};
    endcase
  endfunction

  initial begin
    clock_in = 1'b0;
    rst_n_in = 1'b0;
    input_data_format_in = 8'h00;
    power_state_in = PWR_NORMAL;
    filter_cfg_in = FILTER_CFG_RESET;
    display_mode_in = 5'h00;
    bus_clock_is_output_in = 1'b0;
    master_clock_mode_in = 1'b0;
    field_start_in = 1'b0;
    line_number_in = 10'h000;
    svideo_sense_in = 1'b0;
    composite_sense_in = 1'b0;
    err_total = 0;
    n_tests = 0;
    cycles = 0;
    seq = '{PWR_NORMAL, PWR_SVIDEO_OFF, PWR_COMPOSITE_OFF, PWR_DOWN, PWR_FULL_DOWN, PWR_NORMAL};
    // Reset values, reset held over two edges
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    #1;
    check(power_ctl_out, 6'h39);
    check({active_state_out, deflicker_lines_out, connection_status_out}, 8'h08);
    // Flicker clamp, text enhance, gain, peaking on a narrow band
    cfg_a = {2'h3, 2'h1, 1'b1, 2'h2, 1'b1, 2'h1, 1'b1, 1'b0};
    cfg_b = {2'h0, 2'h3, 1'b0, 2'h0, 1'b0, 2'h3, 1'b1, 1'b0};
    field(PWR_NORMAL, cfg_a, 8'h40);
    check(filter_cfg_out, {2'h2, cfg_a[9:0]});
    check(dac_gain_select_out, 1'b1);
    // Change between field starts must be held off
    @(posedge clock_in);
    filter_cfg_in        <= cfg_b;
    input_data_format_in <= 8'hBF;
    tick(4);
    check(filter_cfg_out, {2'h2, cfg_a[9:0]});
    check(dac_gain_select_out, 1'b1);
    field(PWR_NORMAL, cfg_b, 8'hBF);
    check(filter_cfg_out, {4'h2, cfg_b[7:0]});
    check(dac_gain_select_out, 1'b0);
    // Every chroma and S-Video luma code with peaking requested
    for (int i = 0; i < 4; i++) begin
      cfg_a = {2'h1, 2'h0, i[0], i[1:0], i[0], i[1:0], 1'b1, 1'b0};
      field(PWR_NORMAL, cfg_a, 8'h00);
      check(filter_cfg_out, cfg_a);
      check(svideo_luma_band_out, i[1] ? 2'h2 : i[1:0]);
      check(svideo_peaking_active_out, !i[1]);
    end
    // Deflicker span at first mode and clamped out-of-range mode
    @(posedge clock_in);
    display_mode_in <= 5'h00;
    field(PWR_NORMAL, cfg_a, 8'h00);
    check(deflicker_lines_out, DEFLICKER_MIN + DEFLICKER_TABLE[1:0]);
    @(posedge clock_in);
    display_mode_in <= 5'h1F;
    field(PWR_NORMAL, cfg_a, 8'h00);
    check(deflicker_lines_out, DEFLICKER_MIN + DEFLICKER_TABLE[57:56]);
    // Walk through every operating state
    @(posedge clock_in);
    bus_clock_is_output_in <= 1'b1;
    master_clock_mode_in   <= 1'b1;
    foreach (seq[k]) begin
      field(seq[k], cfg_a, 8'h00);
      check(active_state_out, seq[k]);
      check(power_ctl_out, pexp(seq[k], 1'b1, 1'b1));
    end
    // Out-of-range state code falls back to normal
    field(power_state_t'(3'h7), cfg_a, 8'h00);
    check(active_state_out, PWR_NORMAL);
    check(power_ctl_out, pexp(PWR_NORMAL, 1'b1, 1'b1));
    // Pixel clock follows master mode only while powered down
    field(PWR_DOWN, cfg_a, 8'h00);
    @(posedge clock_in);
    master_clock_mode_in <= 1'b0;
    tick(3);
    check(power_ctl_out, pexp(PWR_DOWN, 1'b1, 1'b0));
    // VBI pass-through window edges
    field(PWR_NORMAL, {10'h000, 2'h1}, 8'h00);
    line_chk(10'h009, 1'b0);
    line_chk(VBI_FIRST_LINE, 1'b1);
    line_chk(VBI_LAST_LINE, 1'b1);
    line_chk(10'h016, 1'b0);
    field(PWR_DOWN, {10'h000, 2'h1}, 8'h00);
    line_chk(10'h00F, 1'b0);
    // TV sense combinations
    for (int j = 1; j < 5; j++) begin
      @(posedge clock_in);
      svideo_sense_in    <= j[1];
      composite_sense_in <= j[0];
      tick(8);
      check(connection_status_out, j[1:0]);
    end
    end_of_test();
  end
endmodule
